// File: logic/wdsm_pkg.sv
/*
 * Package for the watchdog status and pulse monitor: status word layout,
 * reset values and pulse watchdog timing counts.
 * Assumes a 125 MHz system clock.
 */
`default_nettype none
package wdsm_pkg;
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
    // Status word field positions
    localparam int unsigned ST_CNT_LSB     = 3;
    localparam int unsigned ST_EARLY_ANSW  = 7;
    localparam int unsigned ST_LATE_ANSW   = 8;
    localparam int unsigned ST_BAD_ANSW    = 9;
    localparam int unsigned ST_EARLY_REQ   = 10;
    localparam int unsigned ST_LATE_REQ    = 11;
    localparam int unsigned ST_RST_TO_ANSW = 12;
    localparam int unsigned ST_RST_TO_REQ  = 13;
    localparam int unsigned ST_RST_CNT     = 14;
    localparam int unsigned ST_EVT_LSB     = 16;
    localparam int unsigned NUM_FLAGS      = 8;
    // Reset values
    localparam logic [3:0] ERR_CNT_RESET   = 4'h7;
    localparam logic [3:0] EVT_CNT_RESET   = 4'h0;
    // Pulse watchdog times in ms, overfrequency in us (least times round up, so use mins)
    localparam int unsigned QUIESCENT_MS   = 200;
    localparam int unsigned RESET_HIGH_MS  = 200;
    localparam int unsigned RESET_LOW_MS   = 10;
    localparam int unsigned TOFF_SHORT_MS  = 11;
    localparam int unsigned TOFF_LONG_MS   = 22;
    localparam int unsigned OVERFREQ_US    = 1000;
    // Cycle counts
    localparam int unsigned QUIESCENT_CYC  = QUIESCENT_MS * CLK_PER_MS;
    localparam int unsigned RESET_HIGH_CYC = RESET_HIGH_MS * CLK_PER_MS;
    localparam int unsigned RESET_LOW_CYC  = RESET_LOW_MS * CLK_PER_MS;
    localparam int unsigned TOFF_SHORT_CYC = TOFF_SHORT_MS * CLK_PER_MS;
    localparam int unsigned TOFF_LONG_CYC  = TOFF_LONG_MS * CLK_PER_MS;
    localparam int unsigned OVERFREQ_CYC   =
        (OVERFREQ_US * (CLK_HZ / 1_000_000));
    localparam int unsigned TMR_W          = 26;
    localparam int unsigned CFG_SEL_HI     = 14;
    localparam int unsigned CFG_SEL_LO     = 13;

    typedef enum logic [1:0] {
        WDSM_IDLE  = 2'b00,
        WDSM_WATCH = 2'b01,
        WDSM_LOW   = 2'b10,
        WDSM_HIGH  = 2'b11
    } wdsm_state_t;
endpackage : wdsm_pkg
`default_nettype wire

// File: logic/wdsm_sync.sv
/*
 * Two-stage synchroniser for one level.
 * Assumes the input may change at any time relative to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module wdsm_sync (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic stage1;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : wdsm_sync
`default_nettype wire

// File: logic/wdsm_pulse_wd.sv
/*
 * Pulse watchdog: rising edge interval checking, timeout and the
 * repeating reset pattern with quiescent wait.
 * Assumes a synchronised pulse level and disable level.
 */
`timescale 1ns/1ps
`default_nettype none
module wdsm_pulse_wd (
    input  wire logic                     clock_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     pulse_sync_in,
    input  wire logic                     disable_in,
    input  wire logic                     long_timeout_in,
    output var  logic                     reset_n_out,
    output var  logic                     fault_flag_out
);
    import wdsm_pkg::*;

    wdsm_state_t              state;
    wdsm_state_t              next_state;
    logic [TMR_W-1:0]         timer;
    logic [TMR_W-1:0]         edge_gap;
    logic                     pulse_prev;
    logic [TMR_W-1:0]         toff_cyc;
    logic [TMR_W-1:0]         next_timer;

    wire rise      = pulse_sync_in && !pulse_prev;
    wire too_fast  = edge_gap < TMR_W'(OVERFREQ_CYC);
    wire good_edge = rise && !too_fast;

    assign toff_cyc = long_timeout_in ? TMR_W'(TOFF_LONG_CYC)
                                      : TMR_W'(TOFF_SHORT_CYC);

    always_comb
    begin
        next_state = state;
        next_timer = timer + 1'b1;
        case (state)
            WDSM_IDLE:
                if (timer >= TMR_W'(QUIESCENT_CYC - 1))
                begin
                    next_state = WDSM_WATCH;
                    next_timer = '0;
                end
            WDSM_WATCH:
                if (good_edge)
                    next_timer = '0;
                else if (timer >= toff_cyc - 1'b1)
                begin
                    next_state = WDSM_LOW;
                    next_timer = '0;
                end
            WDSM_LOW:
                if (timer >= TMR_W'(RESET_LOW_CYC - 1))
                begin
                    next_state = WDSM_HIGH;
                    next_timer = '0;
                end
            WDSM_HIGH:
                // Quiescent wait after release doubles as high time
                if (timer >= TMR_W'(RESET_HIGH_CYC - 1))
                begin
                    next_state = WDSM_WATCH;
                    next_timer = '0;
                end
            default:
            begin
                next_state = WDSM_IDLE;
                next_timer = '0;
            end
        endcase
        if (disable_in)
        begin
            next_state = WDSM_IDLE;
            next_timer = '0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state      <= WDSM_IDLE;
            timer      <= '0;
            pulse_prev <= 1'b0;
            edge_gap   <= '0;
        end
        else
        begin
            state      <= next_state;
            timer      <= next_timer;
            pulse_prev <= pulse_sync_in;
            // Saturate so a long gap never wraps to look fast
            if (rise)
                edge_gap <= '0;
            else if (edge_gap != '1)
                edge_gap <= edge_gap + 1'b1;
        end
    end

    // Registered so the reset pin never glitches on a state change
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reset_n_out <= 1'b1;
        else
            reset_n_out <= (next_state != WDSM_LOW);
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            fault_flag_out <= 1'b0;
        else if (disable_in)
            fault_flag_out <= 1'b0;
        else if (next_state == WDSM_LOW && state == WDSM_WATCH)
            fault_flag_out <= 1'b1;
    end
endmodule : wdsm_pulse_wd
`default_nettype wire

// File: logic/wdsm_top.sv
/*
 * Watchdog status word and pulse watchdog monitor.
 * Assumes the question and answer engine reports its events as one-cycle
 * pulses, and a serial port front end that strobes a status read.
 */
// Notes on behaviour
// - Status word shows the live 4-bit error counter, 7 after reset.
// - Answer before window start sets the early answer flag.
// - Answer after window end sets the late answer flag.
// - In-window answer with wrong value sets the wrong answer flag.
// - Request before window start sets the early request flag.
// - Request after window end sets the late request flag.
// - Reset from answer timeout sets its reset flag.
// - Reset from request timeout sets its reset flag.
// - Reset from error counter reaching zero sets its reset flag.
// - 4-bit reset event count, zero after reset, in status word.
// - Status read clears flags, not error counter nor event count.
// - Watchdog reset keeps parameters; only state machine reset reloads.
// - Pulse watchdog asserts reset on out-of-range rising edge frequency.
// - After reset or disable release, idle for quiescent time first.
// - Missing pulses: reset low, then high 200 ms, repeated.
// - Timeout 11 ms when config bit 14 clear, 22 ms when set.
// - Edges closer than 1 ms do not clear the timer.
// - Config bits 14:13 pick frequency window; bit 14 sets timeout. Window is only output on freq_window_sel_out; the edge check uses a fixed 1 ms.
// - Disable pin stops pulse watchdog, clears timer, no faults.
// - Pulse watchdog reset flag held zero while disabled.
// - Sampled disable level readable over serial port.
// - Parameters writable up to and including the cycle of the first seed request.
`timescale 1ns/1ps
`default_nettype none
module wdsm_top (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic        controller_pulse_input_in,
    input  wire logic        pulse_watchdog_disable_pin_in,
    input  wire logic [15:0] advanced_config_word_in,
    input  wire logic        cfg_write_in,
    input  wire logic        seed_request_in,
    input  wire logic        answer_early_in,
    input  wire logic        answer_late_in,
    input  wire logic        answer_wrong_in,
    input  wire logic        request_early_in,
    input  wire logic        request_late_in,
    input  wire logic        reset_answer_timeout_in,
    input  wire logic        reset_request_timeout_in,
    input  wire logic        reset_counter_zero_in,
    input  wire logic        error_counter_load_in,
    input  wire logic [3:0]  error_counter_in,
    input  wire logic        status_read_in,
    output var  logic [31:0] watchdog_status_word_out,
    output var  logic        qa_watchdog_reset_out,
    output var  logic        cfg_locked_out,
    output var  logic [1:0]  freq_window_sel_out,
    output var  logic        reset_n_out,
    output var  logic        pulse_watchdog_reset_flag_out,
    output var  logic        disable_level_out
);
    import wdsm_pkg::*;

    // Registered status word fields, config state and synchronised inputs
    logic [3:0]            error_counter_value;
    logic [3:0]            reset_event_count;
    logic [NUM_FLAGS-1:0]  flags;
    logic [1:0]            cfg_sel;
    logic                  cfg_locked;
    logic                  pulse_sync;
    logic                  disable_sync;

    // Next values, decoded by continuous assignments
    logic [3:0]            next_error_counter_value;
    logic [3:0]            next_reset_event_count;
    logic [1:0]            next_cfg_sel;
    logic                  next_cfg_locked;
    wire  [NUM_FLAGS-1:0]  next_flags;

    // Event order matches flag bit order in the status word
    wire [NUM_FLAGS-1:0] events = {
        reset_counter_zero_in,
        reset_request_timeout_in,
        reset_answer_timeout_in,
        request_late_in,
        request_early_in,
        answer_wrong_in,
        answer_late_in,
        answer_early_in
    };
    // Three causes of a first watchdog reset
    wire any_wd_reset = reset_counter_zero_in
                      | reset_request_timeout_in
                      | reset_answer_timeout_in;
    // Parameters move only on an unlocked write
    wire cfg_write_ok = cfg_write_in && !cfg_locked;

    // Sticky flags; a new event in the read cycle survives the clear
    genvar g;
    generate
        for (g = 0; g < NUM_FLAGS; g++)
        begin : g_flag
            assign next_flags[g] = events[g]
                                 | (flags[g] && !status_read_in);

            always_ff @(posedge clock_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    flags[g] <= 1'b0;
                end
                else
                begin
                    flags[g] <= next_flags[g];
                end
            end
        end
    endgenerate

    // Live value moves only on the engine's load strobe
    assign next_error_counter_value = error_counter_load_in
                                    ? error_counter_in
                                    : error_counter_value;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            error_counter_value <= ERR_CNT_RESET;
        end
        else
        begin
            error_counter_value <= next_error_counter_value;
        end
    end

    // Wraps at 15; saturating would hide further events
    assign next_reset_event_count = any_wd_reset
                                  ? reset_event_count + 4'h1
                                  : reset_event_count;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reset_event_count <= EVT_CNT_RESET;
        end
        else
        begin
            reset_event_count <= next_reset_event_count;
        end
    end

    // Locks on the first seed request, stays locked until reset
    assign next_cfg_locked = cfg_locked || seed_request_in;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cfg_locked <= 1'b0;
        end
        else
        begin
            cfg_locked <= next_cfg_locked;
        end
    end

    // A watchdog reset is not seen here; only rst_n_in reloads
    assign next_cfg_sel = cfg_write_ok
                        ? advanced_config_word_in[CFG_SEL_HI:CFG_SEL_LO]
                        : cfg_sel;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cfg_sel <= 2'h0;
        end
        else
        begin
            cfg_sel <= next_cfg_sel;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            qa_watchdog_reset_out <= 1'b0;
        end
        else
        begin
            qa_watchdog_reset_out <= any_wd_reset;
        end
    end

    assign cfg_locked_out      = cfg_locked;
    assign freq_window_sel_out = cfg_sel;

    always_comb
    begin
        watchdog_status_word_out = 32'h0000_0000;
        watchdog_status_word_out[ST_CNT_LSB +: 4] = error_counter_value;
        watchdog_status_word_out[ST_EARLY_ANSW +: NUM_FLAGS] = flags;
        watchdog_status_word_out[ST_EVT_LSB +: 4] = reset_event_count;
    end

    wdsm_sync u_pulse_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in (controller_pulse_input_in),
        .sync_out (pulse_sync)
    );

    wdsm_sync u_dis_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in (pulse_watchdog_disable_pin_in),
        .sync_out (disable_sync)
    );

    assign disable_level_out = disable_sync;

    wdsm_pulse_wd u_pulse_wd (
        .clock_in        (clock_in),
        .rst_n_in        (rst_n_in),
        .pulse_sync_in   (pulse_sync),
        .disable_in      (disable_sync),
        .long_timeout_in (cfg_sel[1]),
        .reset_n_out     (reset_n_out),
        .fault_flag_out  (pulse_watchdog_reset_flag_out)
    );
endmodule : wdsm_top
`default_nettype wire

// File: bench/wdsm_top_sva.sv
/* Checker for the watchdog status word and pulse watchdog ports.
   Assumes it is bound to wdsm_top and sees one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module wdsm_top_sva
    import wdsm_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        rst_n_in,
    input wire logic        answer_early_in,
    input wire logic        answer_late_in,
    input wire logic        answer_wrong_in,
    input wire logic        request_early_in,
    input wire logic        request_late_in,
    input wire logic        reset_answer_timeout_in,
    input wire logic        reset_request_timeout_in,
    input wire logic        reset_counter_zero_in,
    input wire logic        error_counter_load_in,
    input wire logic [3:0]  error_counter_in,
    input wire logic        status_read_in,
    input wire logic        cfg_write_in,
    input wire logic [31:0] watchdog_status_word_out,
    input wire logic        qa_watchdog_reset_out,
    input wire logic        cfg_locked_out,
    input wire logic [1:0]  freq_window_sel_out,
    input wire logic        reset_n_out,
    input wire logic        pulse_watchdog_reset_flag_out,
    input wire logic        disable_level_out
);
    logic [31:0] sw;
    logic        ev_rst;
    logic        ev_any;
    assign sw = watchdog_status_word_out;
    assign ev_rst = reset_answer_timeout_in | reset_request_timeout_in
        | reset_counter_zero_in;
    // Any event beats a read, so reads are judged only when quiet
    assign ev_any = ev_rst | answer_early_in | answer_late_in
        | answer_wrong_in | request_early_in | request_late_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    AST_EARLY_ANSW_SET: assert property (answer_early_in |=> sw[7])
        else $error("early answer flag not set");
    AST_LATE_ANSW_SET: assert property (answer_late_in |=> sw[8])
        else $error("late answer flag not set");
    AST_TO_ANSW_RESET: assert property (reset_answer_timeout_in
        |=> sw[12] && qa_watchdog_reset_out)
        else $error("answer timeout reset missing");
    AST_EVENT_COUNT: assert property (ev_rst
        |=> sw[19:16] == $past(sw[19:16]) + 4'h1)
        else $error("reset event count not advanced");
    AST_READ_CLEAR: assert property (status_read_in && !ev_any
        && !error_counter_load_in
        |=> sw[14:7] == 8'h00 && $stable(sw[19:16]) && $stable(sw[6:3]))
        else $error("status read result wrong");
    AST_STICKY: assert property (sw[9] && !status_read_in |=> sw[9])
        else $error("flag dropped without read");
    AST_ERR_LOAD: assert property (error_counter_load_in
        |=> sw[6:3] == $past(error_counter_in))
        else $error("error counter not shown");
    AST_CFG_LOCK: assert property (cfg_locked_out && cfg_write_in
        |=> $stable(freq_window_sel_out) && cfg_locked_out)
        else $error("locked config changed");
    AST_DIS_QUIET: assert property (disable_level_out
        |=> !pulse_watchdog_reset_flag_out && reset_n_out)
        else $error("fault while disabled");
    COV_RESET_EVENT: cover property (ev_rst);
    COV_READ_FLAG: cover property (status_read_in && sw[7]);
    COV_DISABLED: cover property (disable_level_out);
endmodule : wdsm_top_sva
bind wdsm_top wdsm_top_sva u_sva (.clock_in, .rst_n_in, .answer_early_in,
    .answer_late_in, .answer_wrong_in, .request_early_in, .request_late_in,
    .reset_answer_timeout_in, .reset_request_timeout_in,
    .reset_counter_zero_in, .error_counter_load_in, .error_counter_in,
    .status_read_in, .cfg_write_in, .watchdog_status_word_out,
    .qa_watchdog_reset_out, .cfg_locked_out, .freq_window_sel_out,
    .reset_n_out, .pulse_watchdog_reset_flag_out, .disable_level_out);
`default_nettype wire

// File: bench/wdsm_pulse_src.sv
/* Controller pulse source model.
   Assumes the monitor samples the line on its own clock. */
`timescale 1ns/1ps
`default_nettype none
module wdsm_pulse_src #(
    parameter int HALF_CYC = 125000
) (
    input  wire logic clock_in,
    input  wire logic run_in,
    output var  logic pulse_out
);
    int cnt = 0;
    // 2 ms period sits inside every selectable window
    always @(posedge clock_in)
    begin
        if (!run_in || cnt == HALF_CYC - 1)
        begin
            cnt <= 0;
            pulse_out <= run_in & ~pulse_out;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
endmodule : wdsm_pulse_src
`default_nettype wire

// File: bench/tb.sv
/* Self-checking bench for the watchdog status and pulse monitor.
   Assumes event inputs are one-cycle strobes from the bench, except the 13-cycle run of back to back resets. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wdsm_pkg::*;
    logic        clock_in;
    logic        rst_n_in;
    logic        pulse;
    logic        dis;
    logic [15:0] cfg;
    logic [7:0]  ev;
    logic [3:0]  ctl;
    logic [3:0]  ecnt;
    logic [31:0] sw;
    logic        qa;
    logic        lock;
    logic [1:0]  sel;
    logic        rstn;
    logic        flag;
    logic        dlev;
    logic [3:0]  evt;
    logic [3:0]  cnt_e;
    int          bad_count = 0;
    int          total_checks = 0;

    wdsm_pulse_src src (.clock_in(clock_in), .run_in(rst_n_in),
        .pulse_out(pulse));
    wdsm_top dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .controller_pulse_input_in(pulse),
        .pulse_watchdog_disable_pin_in(dis),
        .advanced_config_word_in(cfg), .cfg_write_in(ctl[2]),
        .seed_request_in(ctl[3]), .answer_early_in(ev[0]),
        .answer_late_in(ev[1]), .answer_wrong_in(ev[2]),
        .request_early_in(ev[3]), .request_late_in(ev[4]),
        .reset_answer_timeout_in(ev[5]), .reset_request_timeout_in(ev[6]),
        .reset_counter_zero_in(ev[7]), .error_counter_load_in(ctl[1]),
        .error_counter_in(ecnt), .status_read_in(ctl[0]),
        .watchdog_status_word_out(sw), .qa_watchdog_reset_out(qa),
        .cfg_locked_out(lock), .freq_window_sel_out(sel),
        .reset_n_out(rstn), .pulse_watchdog_reset_flag_out(flag),
        .disable_level_out(dlev));

    function automatic logic [31:0] exp_sw(input logic [7:0] f);
        return {12'h000, evt, 1'b0, f, cnt_e, 3'b000};
    endfunction : exp_sw

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // Holds the strobes for n edges, then looks after the last one lands
    task automatic step(input logic [7:0] m, input logic [3:0] c,
                        input logic [15:0] d, input int n);
        @(posedge clock_in);
        ev <= m;
        ctl <= c;
        cfg <= d;
        ecnt <= d[3:0];
        repeat (n) @(posedge clock_in);
        ev <= 8'h00;
        ctl <= 4'h0;
        #1;
    endtask : step

    task automatic do_reset;
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (12) @(posedge clock_in);
        #1;
        evt = 4'h0;
        cnt_e = 4'h7;
        check(sw, exp_sw(8'h00));
        check({29'h0, lock, sel}, 32'h0000_0000);
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        #1;
    endtask : do_reset

    task automatic test_done;
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    initial
    begin
        #(3000 * 8);
        bad_count++;
        test_done();
    end

    initial
    begin
        rst_n_in = 1'b0;
        dis = 1'b0;
        cfg = 16'h0000;
        ev = 8'h00;
        ctl = 4'h0;
        ecnt = 4'h0;
        do_reset();
        for (int i = 0; i < 8; i++)
        begin
            step(8'h01 << i, 4'h0, 16'h0000, 1);
            if (i >= 5)
                evt = evt + 4'h1;
            check({31'h0, qa}, {31'h0, i >= 5});
            check(sw, exp_sw(8'h01 << i));
            repeat (3) @(posedge clock_in);
            #1;
            check(sw, exp_sw(8'h01 << i));
            step(8'h00, 4'h1, 16'h0000, 1);
            check(sw, exp_sw(8'h00));
        end
        // Back to back resets run the count through its wrap
        step(8'h80, 4'h0, 16'h0000, 13);
        evt = evt + 4'hd;
        check(sw, exp_sw(8'h80));
        step(8'h04, 4'h1, 16'h0000, 1);
        check(sw, exp_sw(8'h04));
        for (int v = 0; v < 3; v++)
        begin
            step(8'h00, 4'h2, 16'h000f * v[15:0], 1);
            cnt_e = 4'hf * v[3:0];
            step(8'h00, 4'h1, 16'h0000, 1);
            check(sw, exp_sw(8'h00));
        end
        for (int k = 0; k < 4; k++)
        begin
            step(8'h00, 4'h4, 16'(k) << 13, 1);
            check({30'h0, sel}, 32'(k));
        end
        step(8'h00, 4'h8, 16'h0000, 1);
        step(8'h00, 4'h4, 16'h0000, 1);
        check({29'h0, lock, sel}, 32'h0000_0007);
        step(8'h40, 4'h0, 16'h0000, 1);
        evt = evt + 4'h1;
        check({30'h0, sel}, 32'h0000_0003);
        check(sw, exp_sw(8'h40));
        @(posedge clock_in);
        dis <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        check({29'h0, dlev, flag, rstn}, 32'h0000_0005);
        @(posedge clock_in);
        dis <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        check({30'h0, dlev, rstn}, 32'h0000_0001);
        do_reset();
        test_done();
    end
endmodule : tb
`default_nettype wire
